// file: logic/rtp_pin_edge.sv
// pin synchroniser with rising and falling edge detect
`timescale 1ns/1ps
module rtp_pin_edge (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic clock_en_i,
	input wire logic pin_i,
	output logic rise_o,
	output logic fall_o
);
	logic sync_a;
	logic sync_b;
	logic prev;

	// two stages before anything looks at the pin
	// reset to the pulled-up idle level, so no false rise after reset
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			prev <= 1'b1;
		end else if (clock_en_i) begin
			sync_a <= pin_i;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	// edges seen only on the settled copy
	assign rise_o = sync_b & ~prev;
	assign fall_o = ~sync_b & prev;
endmodule

// file: logic/rtp_pkg.sv
// constants and types shared by the reload timer files
package rtp_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_RELOAD_B_LO = 8'hA7;
	localparam logic [7:0] IDX_RELOAD_B_HI = 8'hA8;
	localparam logic [7:0] IDX_RELOAD_A_LO = 8'hAA;
	localparam logic [7:0] IDX_RELOAD_A_HI = 8'hAB;
	localparam logic [7:0] IDX_COUNT_LO = 8'hAC;
	localparam logic [7:0] IDX_COUNT_HI = 8'hAD;
	localparam logic [7:0] IDX_CONTROL = 8'hAE;
	localparam logic [7:0] IDX_PORT_DATA = 8'hB2;
	localparam logic [7:0] IDX_PORT_DIR = 8'hB3;
	localparam logic [7:0] IDX_FLAGS = 8'hCF;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PIN_BIT = 2;
	localparam int GIE_BIT = 4;

	// ------------------------------------------------------------
	// mode codes held in control bits 7..5
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_WAVE_TOGGLE = 3'h5;
	localparam logic [2:0] MODE_WAVE_PLAIN = 3'h4;
	localparam logic [2:0] MODE_EVENT_RISE = 3'h0;
	localparam logic [2:0] MODE_EVENT_FALL = 3'h1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// control register layout, msb first
	typedef struct packed {
		logic [2:0] mode;
		logic run;
		logic pend;
		logic irq_en;
		logic capt_type;
		logic dual;
	} rtp_ctrl_t;

	// which reload register feeds the next underflow
	typedef enum logic {
		RLD_A,
		RLD_B
	} rtp_rsel_t;

endpackage

// file: logic/rtp_timer.sv
// reload timer with waveform and event counter modes, avalon slave
//
// Behaviour
// - waveform mode decrements the count every clock while run is set.
// - waveform underflow loads the selected reload value and counts on.
// - every underflow sets pending flag, control bit 3.
// - toggle mode inverts the timer pin (port bit 2) on underflow.
// - dual select 0 reloads only from reload_a, reload_b ignored.
// - dual select 1 alternates a then b, starting with a after start.
// - irq request only while irq enable and global enable are both set.
// - one interrupt per pending set; new one only after clear.
// - in toggle mode irq comes with each pin rising and falling edge.
// - control 0xB0 gives toggling waveform, irq off, pending cleared, run.
// - pin start level from port data bit 2, output via direction bit 2.
// - event mode decrements on selected pin transitions, not clock.
// - control bit 5 picks falling or rising edges in event mode.
// - event underflow reloads from reload_a, sets pending, keeps counting.
// - count reaches zero on event N, underflows on next event.
// - control 0x34 gives falling event count, irq on, pending clear, run.
// - control bits 7..5: 101 toggle, 100 plain wave, 000 rise, 001 fall.
// - control bit 4 run, bit 2 irq enable, bit 0 dual select.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module rtp_timer
	import rtp_pkg::*;
#(
	parameter int CW = CNT_W
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic clock_en_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic timer_pin_i,
	output logic timer_pin_o,
	output logic timer_pin_oe_n_o,
	output logic timer_irq_request_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rtp_ctrl_t ctrl;
	rtp_ctrl_t next_ctrl;
	logic [CW-1:0] timer_count;
	logic [CW-1:0] next_count;
	logic [CW-1:0] reload_a;
	logic [CW-1:0] reload_b;
	logic [7:0] port_data_reg;
	logic [7:0] port_direction_reg;
	logic [7:0] next_port_data;
	logic global_ie;
	rtp_rsel_t rsel;
	rtp_rsel_t next_rsel;
	logic pin_rise;
	logic pin_fall;

	// ------------------------------------------------------------
	// pin edges
	// ------------------------------------------------------------
	rtp_pin_edge u_edge (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.clock_en_i(clock_en_i),
		.pin_i(timer_pin_i),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// a write lands at the edge where waitrequest is seen low
	wire [7:0] idx = avs_address_i[ADDR_W-1:2];
	wire wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	wire [7:0] wd = avs_writedata_i[7:0];
	wire wr_ctrl = wr & (idx == IDX_CONTROL);
	wire wr_cnt_lo = wr & (idx == IDX_COUNT_LO);
	wire wr_cnt_hi = wr & (idx == IDX_COUNT_HI);
	wire wr_ra_lo = wr & (idx == IDX_RELOAD_A_LO);
	wire wr_ra_hi = wr & (idx == IDX_RELOAD_A_HI);
	wire wr_rb_lo = wr & (idx == IDX_RELOAD_B_LO);
	wire wr_rb_hi = wr & (idx == IDX_RELOAD_B_HI);
	wire wr_pdata = wr & (idx == IDX_PORT_DATA);
	wire wr_pdir = wr & (idx == IDX_PORT_DIR);
	wire wr_flags = wr & (idx == IDX_FLAGS);
	wire cnt_wr = wr_cnt_lo | wr_cnt_hi;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	// capture mode codes (01x, 11x) never tick: they are not built
	wire wave = (ctrl.mode == MODE_WAVE_TOGGLE) |
		(ctrl.mode == MODE_WAVE_PLAIN);
	wire evt = (ctrl.mode == MODE_EVENT_RISE) |
		(ctrl.mode == MODE_EVENT_FALL);
	wire evt_edge = (ctrl.mode == MODE_EVENT_FALL) ? pin_fall :
		pin_rise;
	wire tick = clock_en_i & ctrl.run &
		(wave | (evt & evt_edge));
	// zero is a real count; underflow needs one more tick
	wire underflow = tick & (timer_count == '0);
	wire use_b = wave & ctrl.dual & (rsel == RLD_B);
	wire [CW-1:0] reload_val = use_b ? reload_b :
		reload_a;
	wire toggle = underflow &
		(ctrl.mode == MODE_WAVE_TOGGLE);
	wire start = wr_ctrl & wd[4] & ~ctrl.run;
	wire irq_next = ctrl.pend & ctrl.irq_en & global_ie;

	// next count: a software write beats a tick in the same cycle
	always_comb begin
		next_count = timer_count;
		if (wr_cnt_lo) begin
			next_count[7:0] = wd;
		end else if (wr_cnt_hi) begin
			next_count[CW-1:8] = wd[CW-9:0];
		end else if (underflow) begin
			next_count = reload_val;
		end else if (tick) begin
			next_count = timer_count - {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// reload select restarts at a each time the timer is started
	always_comb begin
		next_rsel = rsel;
		if (start) begin
			next_rsel = RLD_A;
		end else if (underflow & wave & ctrl.dual) begin
			next_rsel = (rsel == RLD_A) ? RLD_B : RLD_A;
		end
	end

	// control: pending set by underflow wins over a software clear
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = rtp_ctrl_t'(wd);
		end
		if (underflow) begin
			next_ctrl.pend = 1'b1;
		end
	end

	// port data: hardware toggle beats a software write
	always_comb begin
		next_port_data = port_data_reg;
		if (wr_pdata) begin
			next_port_data = wd;
		end
		if (toggle) begin
			next_port_data[PIN_BIT] = ~port_data_reg[PIN_BIT];
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// all state freezes while the clock enable is low
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl <= rtp_ctrl_t'(CTRL_RST);
			rsel <= RLD_A;
			timer_count <= WORD_RST;
			port_data_reg <= BYTE_RST;
			port_direction_reg <= BYTE_RST;
			global_ie <= 1'b0;
		end else if (clock_en_i) begin
			ctrl <= next_ctrl;
			rsel <= next_rsel;
			timer_count <= next_count;
			port_data_reg <= next_port_data;
			if (wr_pdir) port_direction_reg <= wd;
			if (wr_flags) global_ie <= wd[GIE_BIT];
		end
	end

	// reload registers, written byte by byte
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reload_a <= WORD_RST;
			reload_b <= WORD_RST;
		end else if (clock_en_i) begin
			if (wr_ra_lo) reload_a[7:0] <= wd;
			if (wr_ra_hi) reload_a[CW-1:8] <= wd[CW-9:0];
			if (wr_rb_lo) reload_b[7:0] <= wd;
			if (wr_rb_hi) reload_b[CW-1:8] <= wd[CW-9:0];
		end
	end

	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	// every access takes one wait cycle; read data registered
	logic [7:0] rd_byte;
	always_comb begin
		case (idx)
			IDX_CONTROL: rd_byte = next_ctrl;
			IDX_COUNT_LO: rd_byte = next_count[7:0];
			IDX_COUNT_HI: rd_byte = next_count[CW-1:8];
			IDX_RELOAD_A_LO: rd_byte = reload_a[7:0];
			IDX_RELOAD_A_HI: rd_byte = reload_a[CW-1:8];
			IDX_RELOAD_B_LO: rd_byte = reload_b[7:0];
			IDX_RELOAD_B_HI: rd_byte = reload_b[CW-1:8];
			IDX_PORT_DATA: rd_byte = next_port_data;
			IDX_PORT_DIR: rd_byte = port_direction_reg;
			IDX_FLAGS: rd_byte = {3'h0, global_ie, 4'h0};
			default: rd_byte = BYTE_RST;
		endcase
	end

	wire req = avs_read_i | avs_write_i;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= RDATA_RST;
		end else if (clock_en_i) begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
			if (avs_read_i & avs_waitrequest_o)
				avs_readdata_o <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// pin and interrupt outputs
	// ------------------------------------------------------------
	// pin level and enable straight from the port registers
	assign timer_pin_o = port_data_reg[PIN_BIT];
	wire next_port_dir_bit = wr_pdir ? wd[PIN_BIT] :
		port_direction_reg[PIN_BIT];
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			timer_pin_oe_n_o <= 1'b1;
			timer_irq_request_o <= 1'b0;
		end else if (clock_en_i) begin
			timer_pin_oe_n_o <= ~next_port_dir_bit;
			timer_irq_request_o <= irq_next;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_dual_uflow;
		underflow & wave & ctrl.dual & ~start;
	endsequence

	// an underflow that must reload from reload_b
	sequence s_dual_on_b;
		s_dual_uflow ##0 ((rsel == RLD_B) & ~cnt_wr);
	endsequence

	chk_wave_decrement: assert property (
		(tick & wave & (timer_count != '0) & ~cnt_wr) |=>
		(timer_count == $past(timer_count) - 1'b1))
		else $error("waveform count did not step down");

	chk_reload_value: assert property (
		(underflow & ~cnt_wr) |=> (timer_count == $past(reload_val)))
		else $error("underflow did not load the reload value");

	chk_pend_set: assert property (
		underflow |=> ctrl.pend)
		else $error("pending flag not set on underflow");

	chk_pin_toggle: assert property (
		(toggle & ~wr_pdata) |=> (timer_pin_o != $past(timer_pin_o)))
		else $error("pin did not toggle on underflow");

	chk_plain_hold: assert property (
		(underflow & (ctrl.mode == MODE_WAVE_PLAIN) & ~wr_pdata) |=>
		$stable(timer_pin_o))
		else $error("pin moved in plain waveform mode");

	chk_single_reload: assert property (
		(underflow & ~ctrl.dual & ~cnt_wr) |=>
		(timer_count == $past(reload_a)))
		else $error("single reload did not use reload_a");

	chk_dual_alternate: assert property (
		s_dual_uflow ##0 (rsel == RLD_A) |=> (rsel == RLD_B))
		else $error("dual reload did not alternate");

	chk_dual_back: assert property (
		s_dual_uflow ##0 (rsel == RLD_B) |=> (rsel == RLD_A))
		else $error("dual reload did not return to reload_a");

	chk_dual_use_b: assert property (
		s_dual_on_b |=> (timer_count == $past(reload_b)))
		else $error("dual reload did not load reload_b");

	chk_irq_gate: assert property (
		timer_irq_request_o |-> $past(ctrl.irq_en & global_ie & ctrl.pend))
		else $error("irq raised without both enables");

	chk_irq_follow: assert property (
		(clock_en_i & irq_next) |=> timer_irq_request_o)
		else $error("irq did not follow a pending flag");

	chk_event_count: assert property (
		(clock_en_i & ctrl.run & evt & ~evt_edge & ~cnt_wr) |=>
		$stable(timer_count))
		else $error("event counter moved without an edge");

	chk_event_reload: assert property (
		(underflow & evt & ~cnt_wr) |=>
		((timer_count == $past(reload_a)) & ctrl.pend))
		else $error("event underflow reload wrong");
endmodule

// file: tb/rtp_pin_model.sv
// far-side event source and pin load for the reload timer bench
`timescale 1ns/1ps
module rtp_pin_model (
	input wire logic clock_i,
	input wire logic level_i,
	input wire logic drive_i,
	input wire logic oe_n_i,
	output logic pin_o
);
	logic held;

	// ------------------------------------------------------------
	// source level, moved only on clock edges
	// ------------------------------------------------------------
	// each level lasts whole cycles, never a glitch
	always_ff @(posedge clock_i) begin
		held <= level_i;
	end

	// the timer's drive wins when enabled, else the pulled-up source
	assign pin_o = oe_n_i ? held : drive_i;
endmodule

// file: tb/tb_rtp_timer.sv
// self-checking bench for the reload timer
`timescale 1ns/1ps
module tb_rtp_timer;
	import rtp_pkg::*;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, lvl = 1;
	logic [ADDR_W-1:0] adr = '0;
	logic [DATA_W-1:0] wd = '0;
	logic [DATA_W-1:0] rdat;
	logic wait_r, pin_o, oe_n, irq, pin_w;
	logic [7:0] q;
	int fails = 0, samples_checked = 0, cyc = 0, n, wt;

	rtp_timer DUT (.clock_i(clk), .resetn_i(rst_n), .clock_en_i(1'b1),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
		.timer_pin_i(pin_w), .timer_pin_o(pin_o),
		.timer_pin_oe_n_o(oe_n), .timer_irq_request_o(irq));
	rtp_pin_model src (.clock_i(clk), .level_i(lvl), .drive_i(pin_o),
		.oe_n_i(oe_n), .pin_o(pin_w));

	// ------------------------------------------------------------
	// clock, watchdog, verdict
	// ------------------------------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	// runs take a few hundred cycles, so this only trips on a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	// ------------------------------------------------------------
	// avalon master: hold request until waitrequest seen low
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		adr <= ADDR_W'({idx, 2'b00});
		wd <= {24'h00_0000, d};
		if (w) wr <= 1'b1;
		else rd <= 1'b1;
		wt = 0;
		// waitrequest and readdata seen as they stand at the edge
		@(posedge clk);
		while (wait_r !== 1'b0) begin
			@(posedge clk);
			wt++;
		end
		q = rdat[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cyc_n(input int k);
		repeat (k) @(posedge clk);
	endtask
	// cycles until the pin output next changes
	task automatic gap();
		logic p;
		p = pin_o;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pin_o === p && n < 200);
		@(posedge clk);
	endtask
	// one event pulse, low for three cycles then high for six
	task automatic pulse();
		lvl <= 1'b0;
		cyc_n(3);
		lvl <= 1'b1;
		cyc_n(6);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		bus(0, IDX_CONTROL, 8'h00);
		chk("ctrl", 8'h00, q);
		chk("wait cycles", 8'h01, 8'(wt));
		chk("oe_n", 8'h01, {7'h00, oe_n});
		chk("irq", 8'h00, {7'h00, irq});
	endtask
	task automatic t_toggle();
		bus(1, IDX_PORT_DIR, 8'h04);
		bus(1, IDX_PORT_DATA, 8'h04);
		chk("oe_n", 8'h00, {7'h00, oe_n});
		chk("pin start", 8'h01, {7'h00, pin_o});
		bus(1, IDX_COUNT_LO, 8'h03);
		bus(1, IDX_RELOAD_A_LO, 8'h05);
		bus(1, IDX_RELOAD_B_LO, 8'h04);
		bus(1, IDX_CONTROL, 8'hB0);
		gap();
		chk("first gap", 8'h04, 8'(n));
		gap();
		chk("gap", 8'h06, 8'(n));
		gap();
		chk("gap b ignored", 8'h06, 8'(n));
		bus(0, IDX_CONTROL, 8'h00);
		chk("pending", 8'hB8, q);
		chk("irq off", 8'h00, {7'h00, irq});
	endtask
	task automatic t_dual();
		bus(1, IDX_CONTROL, 8'h00);
		bus(1, IDX_RELOAD_A_LO, 8'h02);
		bus(1, IDX_COUNT_LO, 8'h01);
		bus(1, IDX_CONTROL, 8'hB1);
		gap();
		gap();
		chk("gap a", 8'h03, 8'(n));
		gap();
		chk("gap b", 8'h05, 8'(n));
		gap();
		chk("gap a again", 8'h03, 8'(n));
	endtask
	task automatic t_plain();
		logic p;
		bus(1, IDX_CONTROL, 8'h91);
		p = pin_o;
		cyc_n(30);
		chk("pin held", 8'(p), 8'(pin_o));
		bus(0, IDX_CONTROL, 8'h00);
		chk("plain pend", 8'h99, q);
	endtask
	task automatic t_event(input logic [7:0] cv);
		bus(1, IDX_CONTROL, 8'h00);
		bus(1, IDX_PORT_DIR, 8'h00);
		bus(1, IDX_FLAGS, 8'h10);
		bus(1, IDX_COUNT_LO, 8'h02);
		bus(1, IDX_RELOAD_A_LO, 8'h02);
		bus(1, IDX_CONTROL, cv);
		cyc_n(10);
		bus(0, IDX_COUNT_LO, 8'h00);
		chk("no tick on clock", 8'h02, q);
		pulse();
		pulse();
		bus(0, IDX_CONTROL, 8'h00);
		chk("zero no pend", cv, q);
		bus(0, IDX_COUNT_LO, 8'h00);
		chk("count zero", 8'h00, q);
		pulse();
		bus(0, IDX_CONTROL, 8'h00);
		chk("pend on n", cv | 8'h08, q);
		bus(0, IDX_COUNT_LO, 8'h00);
		chk("reloaded", 8'h02, q);
		// software total: one underflow is three events, plus used count
		chk("event total", 8'h03, 8'(3 + 2 - q));
		chk("irq", 8'h01, {7'h00, irq});
		// pending kept set, only the enable dropped
		bus(1, IDX_CONTROL, (cv | 8'h08) & 8'hFB);
		cyc_n(2);
		chk("irq masked", 8'h00, {7'h00, irq});
		bus(1, IDX_CONTROL, cv);
		cyc_n(2);
		chk("irq clear", 8'h00, {7'h00, irq});
		repeat (3) pulse();
		chk("irq again", 8'h01, {7'h00, irq});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc_n(6);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_toggle();
		t_dual();
		t_plain();
		t_event(8'h34);
		t_event(8'h14);
		final_report();
	end
endmodule
